// *** core/lpd_top.sv ***
// led polarity and duty mapping stage for eleven led driver pins
`timescale 1ns/10ps
module lpd_top
    import lpd_pkg::*;
#(
    parameter int DIV = STEP_DIV
) (
    // clock and reset
    input  wire logic                                   CLK,
    input  wire logic                                   RESET,
    // register port from the management bus engine
    input  wire logic [lpd_pkg::ADDR_W-1:0]             REG_ADDR,
    input  wire logic                                   REG_WR,
    input  wire logic [lpd_pkg::REG_W-1:0]              REG_WDATA,
    output logic      [lpd_pkg::REG_W-1:0]              REG_RDATA,
    // configuration from neighbouring registers
    input  wire logic                                   HOLD_MIRROR,
    input  wire logic [lpd_pkg::NUM_CH-1:0]             DRIVE_REQUEST,
    input  wire logic [lpd_pkg::NUM_CH-1:0]             TOUCH_LINKED,
    input  wire logic [lpd_pkg::LOW_CH-1:0]             PIN_DIRECTION,
    input  wire logic [lpd_pkg::LOW_CH-1:0]             PIN_DRIVE_STYLE,
    // duty settings from the behaviour engine
    input  wire logic [lpd_pkg::NUM_CH-1:0]             BREATHE_EN,
    input  wire logic [lpd_pkg::NUM_CH*lpd_pkg::DUTY_W-1:0] MIN_DUTY,
    input  wire logic [lpd_pkg::NUM_CH*lpd_pkg::DUTY_W-1:0] MAX_DUTY,
    input  wire logic [lpd_pkg::NUM_CH*lpd_pkg::DUTY_W-1:0] RAMP_DUTY,
    // state seen by the rest of the device
    output logic      [lpd_pkg::NUM_CH-1:0]             SENSE,
    output logic      [lpd_pkg::NUM_CH-1:0]             DUTY_REF_FLIP,
    // led pins
    output logic      [lpd_pkg::NUM_CH-1:0]             LED_OUT,
    output logic      [lpd_pkg::NUM_CH-1:0]             LED_OE_N
);
    import lpd_pkg::*;

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic [NUM_CH-1:0] sense;
        logic [NUM_CH-1:0] flip;
        logic [REG_W-1:0]  rdata;
        logic [NUM_CH-1:0] pin_out;
        logic [NUM_CH-1:0] pin_oe_n;
    } lpd_top_state_t;

    lpd_top_state_t    state;
    lpd_top_state_t    next_state;
    logic [DUTY_W-1:0] phase;

    // ************************************************
    // helpers
    // ************************************************

    // flip measures a setting from the full scale end
    function automatic logic [DUTY_W-1:0] lpd_ref(
        input logic [DUTY_W-1:0] setting,
        input logic              flip
    );
        logic [DUTY_W-1:0] s;
        s = (setting > DUTY_FULL) ? DUTY_FULL : setting;
        return flip ? (DUTY_FULL - s) : s;
    endfunction

    // keeps a ramp value between its two end points in either order
    function automatic logic [DUTY_W-1:0] lpd_clamp(
        input logic [DUTY_W-1:0] v,
        input logic [DUTY_W-1:0] a,
        input logic [DUTY_W-1:0] b
    );
        logic [DUTY_W-1:0] lo;
        logic [DUTY_W-1:0] hi;
        lo = (a < b) ? a : b;
        hi = (a < b) ? b : a;
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic [DUTY_W-1:0] lpd_field(
        input logic [NUM_CH*DUTY_W-1:0] bus,
        input int                       ch
    );
        return bus[ch*DUTY_W +: DUTY_W];
    endfunction

    // ************************************************
    // period phase
    // ************************************************
    lpd_pwm #(
        .DIV   (DIV)
    ) u_pwm (
        .CLK   (CLK),
        .RESET (RESET),
        .PHASE (phase)
    );

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        logic [NUM_CH-1:0] wr_mask;
        logic [NUM_CH-1:0] wr_val;
        logic [DUTY_W-1:0] dmin;
        logic [DUTY_W-1:0] dmax;
        logic [DUTY_W-1:0] duty;
        logic              active;
        logic              asserted;
        logic              level;
        logic              is_out;
        logic              style;
        wr_mask    = '0;
        wr_val     = '0;
        dmin       = DUTY_ZERO;
        dmax       = DUTY_ZERO;
        duty       = DUTY_ZERO;
        active     = 1'b0;
        asserted   = 1'b0;
        level      = 1'b0;
        is_out     = 1'b0;
        style      = STYLE_OPEN_DRAIN;
        next_state = state;

        // register writes
        if (REG_WR) begin
            unique case (REG_ADDR)
                ADDR_SENSE_LOW: begin
                    wr_mask[LOW_LSB +: LOW_CH] = '1;
                    wr_val[LOW_LSB +: LOW_CH]  = REG_WDATA[LOW_CH-1:0];
                end
                ADDR_SENSE_HIGH: begin
                    wr_mask[HIGH_LSB +: HIGH_CH] = '1;
                    wr_val[HIGH_LSB +: HIGH_CH]  = REG_WDATA[HIGH_CH-1:0];
                end
                ADDR_FLIP_LOW: begin
                    next_state.flip[LOW_LSB +: LOW_CH] =
                        REG_WDATA[LOW_CH-1:0];
                end
                ADDR_FLIP_HIGH: begin
                    next_state.flip[HIGH_LSB +: HIGH_CH] =
                        REG_WDATA[HIGH_CH-1:0];
                end
                default: begin
                end
            endcase
        end
        next_state.sense = (state.sense & ~wr_mask) | (wr_val & wr_mask);
        // unless HOLD_MIRROR is set, every written bit is copied, changed or not
        // built on next_state so a direct flip write is not lost
        if (!HOLD_MIRROR) begin
            next_state.flip = (next_state.flip & ~wr_mask)
                            | (wr_val & wr_mask);
        end

        // read mux; bits above the channels read as zero
        unique case (REG_ADDR)
            ADDR_SENSE_LOW: begin
                next_state.rdata = state.sense[LOW_LSB +: LOW_CH];
            end
            ADDR_SENSE_HIGH: begin
                next_state.rdata = {5'h00, state.sense[HIGH_LSB +: HIGH_CH]};
            end
            ADDR_FLIP_LOW: begin
                next_state.rdata = state.flip[LOW_LSB +: LOW_CH];
            end
            ADDR_FLIP_HIGH: begin
                next_state.rdata = {5'h00, state.flip[HIGH_LSB +: HIGH_CH]};
            end
            default: begin
                next_state.rdata = READ_UNMAPPED;
            end
        endcase

        // per channel duty selection then polarity
        for (int ch = 0; ch < NUM_CH; ch++) begin
            dmin = lpd_ref(lpd_field(MIN_DUTY, ch), state.flip[ch]);
            dmax = lpd_ref(lpd_field(MAX_DUTY, ch), state.flip[ch]);
            active = DRIVE_REQUEST[ch] | TOUCH_LINKED[ch];
            if (!active) begin
                duty = dmin;
            end else if (BREATHE_EN[ch]) begin
                duty = lpd_clamp(lpd_field(RAMP_DUTY, ch),
                                 dmin, dmax);
            end else begin
                duty = dmax;
            end
            // asserted share of the period is the duty value
            asserted = (phase < duty);
            // sense clear asserts low, sense set asserts high
            level = state.sense[ch] ? asserted : ~asserted;

            // channels beyond the direction register are always outputs
            if (ch < LOW_CH) begin
                is_out = PIN_DIRECTION[ch];
                style  = PIN_DRIVE_STYLE[ch];
            end else begin
                is_out = 1'b1;
                style  = STYLE_OPEN_DRAIN;
            end

            if (!is_out) begin
                next_state.pin_out[ch]  = 1'b0;
                next_state.pin_oe_n[ch] = 1'b1;
            end else if (style == STYLE_PUSH_PULL) begin
                next_state.pin_out[ch]  = level;
                next_state.pin_oe_n[ch] = 1'b0;
            end else begin
                // open drain: high is released to the pull up
                next_state.pin_out[ch]  = 1'b0;
                next_state.pin_oe_n[ch] = level;
            end
        end
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state.sense    <= {RST_SENSE[HIGH_CH-1:0], RST_SENSE};
            state.flip     <= {RST_FLIP[HIGH_CH-1:0], RST_FLIP};
            state.rdata    <= READ_UNMAPPED;
            state.pin_out  <= '0;
            state.pin_oe_n <= '1;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign REG_RDATA     = state.rdata;
    assign SENSE         = state.sense;
    assign DUTY_REF_FLIP = state.flip;
    assign LED_OUT       = state.pin_out;
    assign LED_OE_N      = state.pin_oe_n;

endmodule

// *** shared/lpd_pkg.sv ***
// constants shared by the led polarity duty mapper
package lpd_pkg;

    // ************************************************
    // channel layout
    // ************************************************
    localparam int NUM_CH      = 11;
    localparam int LOW_CH      = 8;
    localparam int HIGH_CH     = 3;
    localparam int REG_W       = 8;
    localparam int ADDR_W      = 8;
    localparam int DUTY_W      = 8;
    localparam int LOW_LSB     = 0;
    localparam int HIGH_LSB    = 8;

    // ************************************************
    // register offsets and reset values
    // ************************************************
    localparam logic [ADDR_W-1:0] ADDR_SENSE_LOW  = 8'h75;
    localparam logic [ADDR_W-1:0] ADDR_SENSE_HIGH = 8'h76;
    localparam logic [ADDR_W-1:0] ADDR_FLIP_LOW   = 8'h79;
    localparam logic [ADDR_W-1:0] ADDR_FLIP_HIGH  = 8'h7A;
    localparam logic [REG_W-1:0]  RST_SENSE       = 8'h00;
    localparam logic [REG_W-1:0]  RST_FLIP        = 8'h00;
    localparam logic [REG_W-1:0]  READ_UNMAPPED   = 8'h00;

    // ************************************************
    // duty scale and timing
    // ************************************************
    localparam logic [DUTY_W-1:0] DUTY_FULL  = 8'h64;
    localparam logic [DUTY_W-1:0] DUTY_ZERO  = 8'h00;
    localparam int  CLK_HZ        = 40_000_000;
    localparam int  STEP_HZ       = 1_000_000;
    localparam int  STEP_DIV      = CLK_HZ / STEP_HZ;
    localparam int  DIV_W         = 16;

    // pin drive style encoding
    localparam logic STYLE_OPEN_DRAIN = 1'b0;
    localparam logic STYLE_PUSH_PULL  = 1'b1;

endpackage

// *** core/lpd_pwm.sv ***
// shared duty period phase counter with step divider
`timescale 1ns/10ps
module lpd_pwm
    import lpd_pkg::*;
#(
    parameter int DIV = STEP_DIV
) (
    // clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    // period phase
    output logic [lpd_pkg::DUTY_W-1:0] PHASE
);
    import lpd_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0]  div_cnt;
        logic [DUTY_W-1:0] phase;
    } lpd_pwm_state_t;

    lpd_pwm_state_t state;
    lpd_pwm_state_t next_state;

    localparam logic [DIV_W-1:0]  DIV_LAST   = DIV_W'(DIV - 1);
    localparam logic [DUTY_W-1:0] PHASE_LAST = DUTY_FULL - 8'h01;

    // one period is DUTY_FULL steps; the counter never restarts on
    // register writes so a polarity change does not glitch the period
    always_comb begin
        next_state = state;
        if (state.div_cnt == DIV_LAST) begin
            next_state.div_cnt = '0;
            if (state.phase == PHASE_LAST) begin
                next_state.phase = DUTY_ZERO;
            end else begin
                next_state.phase = state.phase + 8'h01;
            end
        end else begin
            next_state.div_cnt = state.div_cnt + 16'h0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign PHASE = state.phase;

endmodule

// *** verif/lpd_led_model.sv ***
// external leds on pull-ups, sunk by the mapper's pins
`timescale 1ns/10ps
module lpd_led_model (
    // pin side
    input  wire logic [10:0] LED_OUT,
    input  wire logic [10:0] LED_OE_N,
    // pad level seen by the led, low means lit
    output logic      [10:0] PAD
);
    // a released pad rises through the pull-up, never holds old data
    assign PAD = (~LED_OE_N & LED_OUT) | LED_OE_N;
endmodule

// *** verif/lpd_top_sva.sv ***
// port checks for the led polarity duty mapper
`timescale 1ns/10ps
module lpd_top_sva
    import lpd_pkg::*;
#(
    parameter int DIV = STEP_DIV
) (
    // clock, reset and register port
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic [7:0]  REG_ADDR,
    input wire logic        REG_WR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic [7:0]  REG_RDATA,
    // configuration, state and pins
    input wire logic        HOLD_MIRROR,
    input wire logic [7:0]  PIN_DIRECTION,
    input wire logic [7:0]  PIN_DRIVE_STYLE,
    input wire logic [87:0] MIN_DUTY,
    input wire logic [87:0] MAX_DUTY,
    input wire logic [10:0] SENSE,
    input wire logic [10:0] DUTY_REF_FLIP,
    input wire logic [10:0] LED_OUT,
    input wire logic [10:0] LED_OE_N
);
    import lpd_pkg::*;
    logic live;
    logic wr_sense;
    // pins lag their cause by one edge, so skip the edge after reset
    always_ff @(posedge CLK) live <= !RESET;
    assign wr_sense = REG_WR &&
        REG_ADDR inside {ADDR_SENSE_LOW, ADDR_SENSE_HIGH};
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    AST_DIR_OFF: assert property (
        live |-> (LED_OE_N[7:0] | $past(PIN_DIRECTION)) == 8'hFF)
        else $error("input pin driven");
    AST_PP_DRIVE: assert property (
        live |-> (LED_OE_N[7:0] & $past(PIN_DIRECTION)
        & $past(PIN_DRIVE_STYLE)) == 8'h00) else $error("push pull off");
    AST_OD_LOW: assert property (
        live |-> (LED_OUT[7:0] & ~$past(PIN_DRIVE_STYLE)) == 8'h00
        && LED_OUT[10:8] == 3'h0) else $error("open drain drove high");
    AST_SENSE_LO: assert property (
        REG_WR && REG_ADDR == ADDR_SENSE_LOW |=>
        SENSE[7:0] == $past(REG_WDATA)) else $error("sense low write");
    AST_MIRROR: assert property (
        REG_WR && !HOLD_MIRROR && REG_ADDR == ADDR_SENSE_LOW |=>
        DUTY_REF_FLIP[7:0] == $past(REG_WDATA)) else $error("no mirror");
    AST_HOLD: assert property (
        wr_sense && HOLD_MIRROR |=> $stable(DUTY_REF_FLIP))
        else $error("mirror moved while held");
    AST_KEEP: assert property (
        !wr_sense |=> $stable(SENSE)) else $error("sense moved alone");
    AST_RD_LO: assert property (
        REG_ADDR == ADDR_SENSE_LOW |=> REG_RDATA == $past(SENSE[7:0]))
        else $error("sense low readback");
    AST_RD_HI: assert property (
        REG_ADDR == ADDR_SENSE_HIGH |=>
        REG_RDATA == {5'h00, $past(SENSE[10:8])}) else $error("high read");
    AST_IDLE_PIN: assert property (
        live && $past(MIN_DUTY[71:64]) == DUTY_ZERO && !$past(DUTY_REF_FLIP[8])
        && $past(MAX_DUTY[71:64]) == DUTY_ZERO |->
        LED_OE_N[8] == !$past(SENSE[8])) else $error("zero duty level");

    cover property (wr_sense && HOLD_MIRROR);
    cover property (live && !PIN_DIRECTION[0]);
    cover property (REG_WR && REG_ADDR == ADDR_SENSE_HIGH);
endmodule

bind lpd_top lpd_top_sva #(.DIV(DIV)) u_sva (.CLK, .RESET, .REG_ADDR,
    .REG_WR, .REG_WDATA, .REG_RDATA, .HOLD_MIRROR, .PIN_DIRECTION,
    .PIN_DRIVE_STYLE, .MIN_DUTY, .MAX_DUTY, .SENSE, .DUTY_REF_FLIP,
    .LED_OUT, .LED_OE_N);

// *** verif/testbench.sv ***
// self-checking bench for the led polarity duty mapper
`timescale 1ns/10ps
module testbench;
    import lpd_pkg::*;
    localparam int DIVB = 2;
    typedef struct {int k; logic [10:0] e;} lpd_note_t;
    logic        CLK = 1'b0, RESET = 1'b1, REG_WR = 1'b0, HOLD_MIRROR = 1'b0;
    logic [7:0]  REG_ADDR = '0, REG_WDATA = '0, REG_RDATA;
    logic [7:0]  PIN_DIRECTION = '0, PIN_DRIVE_STYLE = '0;
    logic [10:0] DRIVE_REQUEST = '0, TOUCH_LINKED = '0, BREATHE_EN = '0;
    logic [10:0] SENSE, DUTY_REF_FLIP, LED_OUT, LED_OE_N, pad;
    logic [10:0] ms = '0, mf = '0, ep, eo, eout, cnt;
    int          lvl_cnt[11];
    logic [87:0] MIN_DUTY = '0, MAX_DUTY = '0, RAMP_DUTY = '0;
    lpd_note_t   q[$];
    lpd_note_t   n;
    int          n_fail = 0, comparisons = 0;
    event        smp;

    lpd_top #(.DIV(DIVB)) dut (.CLK, .RESET, .REG_ADDR, .REG_WR, .REG_WDATA,
        .REG_RDATA, .HOLD_MIRROR, .DRIVE_REQUEST, .TOUCH_LINKED,
        .PIN_DIRECTION, .PIN_DRIVE_STYLE, .BREATHE_EN, .MIN_DUTY,
        .MAX_DUTY, .RAMP_DUTY, .SENSE, .DUTY_REF_FLIP, .LED_OUT, .LED_OE_N);
    lpd_led_model leds (.LED_OUT, .LED_OE_N, .PAD(pad));

    initial forever #12.5 CLK = ~CLK;

    task automatic tick();
        @(posedge CLK);
        #2;
    endtask
    task automatic chk(string nm, logic [10:0] seen, logic [10:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic note(int k, logic [10:0] e);
        q.push_back('{k, e});
        -> smp;
        #0;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        tick();
        REG_WR = 1'b0;
        tick();
        if (a == ADDR_SENSE_LOW) ms[7:0] = d;
        if (a == ADDR_SENSE_HIGH) ms[10:8] = d[2:0];
        if (a == ADDR_FLIP_LOW || (a == ADDR_SENSE_LOW && !HOLD_MIRROR))
            mf[7:0] = d;
        if (a == ADDR_FLIP_HIGH || (a == ADDR_SENSE_HIGH && !HOLD_MIRROR))
            mf[10:8] = d[2:0];
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        REG_ADDR = a;
        tick();
        note(0, {3'h0, e});
    endtask
    // duties are only 0 or 100 so the phase never matters
    task automatic pins();
        logic dir, sty, d;
        for (int c = 0; c < 11; c++) begin
            dir = c < 8 ? PIN_DIRECTION[c] : 1'b1;
            sty = c < 8 ? PIN_DRIVE_STYLE[c] : 1'b0;
            if (DRIVE_REQUEST[c] | TOUCH_LINKED[c])
                d = BREATHE_EN[c] ? RAMP_DUTY[8*c+:8] != 0
                    : (MAX_DUTY[8*c+:8] != 0) ^ mf[c];
            else
                d = (MIN_DUTY[8*c+:8] != 0) ^ mf[c];
            d = ms[c] ? d : !d;
            ep[c] = dir ? d : 1'b1;
            eo[c] = !dir | (!sty & d);
            eout[c] = dir & sty & d;
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial forever begin
        @(smp);
        while (q.size() > 0) begin
            n = q.pop_front();
            case (n.k)
                0: chk("rdata", {3'h0, REG_RDATA}, n.e);
                1: chk("pad", pad, n.e);
                2: chk("oe_n", LED_OE_N, n.e);
                3: chk("sense", SENSE, n.e);
                4: chk("flip", DUTY_REF_FLIP, n.e);
                5: chk("duty_time", cnt, n.e);
                default: chk("out", LED_OUT, n.e);
            endcase
        end
    end

    // about 1100 cycles expected, allow far more
    initial begin
        #500000;
        n_fail++;
        complete_run();
    end

    initial begin
        void'($urandom(32'hC81E));
        repeat (12) tick();
        note(2, 11'h7FF);
        note(3, 11'h000);
        RESET = 1'b0;
        rd(ADDR_SENSE_LOW, 8'h00);
        rd(ADDR_SENSE_HIGH, 8'h00);
        wr(8'h77, 8'hFF);
        rd(8'h77, READ_UNMAPPED);
        $display("test reset and unmapped done");
        for (int i = 0; i < 60; i++) begin
            HOLD_MIRROR = 1'($urandom);
            wr(ADDR_SENSE_LOW, 8'($urandom));
            wr(ADDR_SENSE_HIGH, 8'($urandom));
            if (i % 3 == 0) wr(ADDR_FLIP_LOW, 8'($urandom));
            if (i % 4 == 1) wr(ADDR_FLIP_HIGH, 8'($urandom));
            DRIVE_REQUEST = 11'($urandom);
            TOUCH_LINKED = 11'($urandom & $urandom);
            BREATHE_EN = 11'($urandom);
            PIN_DIRECTION = 8'($urandom | $urandom);
            PIN_DRIVE_STYLE = 8'($urandom);
            for (int c = 0; c < 11; c++) begin
                MIN_DUTY[8*c+:8] = $urandom % 2 ? DUTY_FULL : DUTY_ZERO;
                MAX_DUTY[8*c+:8] = $urandom % 2 ? DUTY_FULL : DUTY_ZERO;
                RAMP_DUTY[8*c+:8] = $urandom % 2 ? DUTY_FULL : DUTY_ZERO;
                // keep the ramp window ordered after the flip
                if (BREATHE_EN[c]) begin
                    MIN_DUTY[8*c+:8] = mf[c] ? DUTY_FULL : DUTY_ZERO;
                    MAX_DUTY[8*c+:8] = mf[c] ? DUTY_ZERO : DUTY_FULL;
                end
            end
            tick();
            tick();
            pins();
            note(1, ep);
            note(2, eo);
            note(3, ms);
            note(4, mf);
            note(6, eout);
            rd(ADDR_SENSE_LOW, ms[7:0]);
            rd(ADDR_SENSE_HIGH, {5'h00, ms[10:8]});
            rd(ADDR_FLIP_LOW, mf[7:0]);
            rd(ADDR_FLIP_HIGH, {5'h00, mf[10:8]});
        end
        $display("test random polarity and pins done");
        // any span of one whole period sees each phase value for exactly DIVB cycles
        HOLD_MIRROR = 1'b0;
        PIN_DIRECTION = 8'hFF;
        PIN_DRIVE_STYLE = 8'hFF;
        DRIVE_REQUEST = '1;
        TOUCH_LINKED = '0;
        BREATHE_EN = '0;
        MIN_DUTY = '0;
        for (int c = 0; c < 11; c++)
            MAX_DUTY[8*c+:8] = 8'($urandom % 101);
        for (int p = 0; p < 2; p++) begin
            wr(ADDR_SENSE_LOW, p ? 8'hFF : 8'h00);
            wr(ADDR_SENSE_HIGH, p ? 8'h07 : 8'h00);
            tick();
            tick();
            for (int c = 0; c < 11; c++)
                lvl_cnt[c] = 0;
            repeat (DIVB * DUTY_FULL) begin
                tick();
                for (int c = 0; c < 11; c++)
                    lvl_cnt[c] += (pad[c] == 1'(p)) ? 1 : 0;
            end
            for (int c = 0; c < 11; c++) begin
                cnt = 11'(lvl_cnt[c]);
                note(5, 11'(DIVB * (p ? DUTY_FULL - MAX_DUTY[8*c+:8]
                                      : MAX_DUTY[8*c+:8])));
            end
        end
        $display("test duty time per period done");
        RESET = 1'b1;
        tick();
        ms = '0;
        mf = '0;
        note(2, 11'h7FF);
        note(3, ms);
        note(4, mf);
        RESET = 1'b0;
        rd(ADDR_SENSE_LOW, 8'h00);
        rd(ADDR_FLIP_HIGH, 8'h00);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
